// ---- panel_pkg.sv ----
// Purpose: shared constants and types for the front panel bus link
// Assumes: one clock mclk at 125 MHz, asynchronous active-high reset
// Notes: panel address map decodes on the captured low address byte
package panel_pkg;
  // ==========================================================
  // address map (low address byte)
  localparam logic [7:0] led_addr = 8'h10;
  localparam logic [7:0] switch_addr = 8'h20;
  localparam logic [7:0] display_addr = 8'h30;
  localparam logic [7:0] nv_base = 8'h80;
  localparam logic [7:0] nv_mask = 8'h80;
  // ==========================================================
  // reset values and timing
  localparam logic [7:0] led_reset = 8'h00;
  localparam int clk_period_ns = 8;
  localparam int poll_time_ms = 30;
  localparam int poll_cycles = (poll_time_ms * 1000000) / clk_period_ns;
  localparam int recall_cycles = 4;
  localparam int nv_words = 128;
  // start bit inside the saved state word
  localparam int start_bit = 0;

  typedef enum logic [2:0] {
    st_recall = 3'b000,
    st_idle = 3'b001,
    st_read_sw = 3'b010,
    st_write_led = 3'b011,
    st_write_nv = 3'b100,
    st_write_disp = 3'b101,
    st_read_nv = 3'b110
  } host_state_t;

  function automatic logic nv_hit(input logic [7:0] a);
    nv_hit = (a & nv_mask) == nv_base;
  endfunction
endpackage

// ---- panel_bus_if.sv ----
// Purpose: multiplexed address/data bus between processor and panel
// Assumes: single clock; data bus resolved from drive enables
// Notes: oe_n low means that party drives data
`timescale 1ns/10ps
interface panel_bus_if;
  logic addr_strobe;
  logic [7:0] ad_host;
  logic ad_host_oe_n;
  logic [7:0] ad_panel;
  logic ad_panel_oe_n;
  logic rd_wr;
  logic data_strobe;
  logic restore_cmd;
  logic supply_low;
  wire [7:0] ad = !ad_host_oe_n ? ad_host : (!ad_panel_oe_n ? ad_panel : 8'hff);
  modport host (output addr_strobe, output ad_host, output ad_host_oe_n, output rd_wr,
    output data_strobe, output restore_cmd, input ad);
  modport panel (input addr_strobe, input ad, input rd_wr, input data_strobe,
    input restore_cmd, input supply_low, output ad_panel, output ad_panel_oe_n);
endinterface

// ---- panel_end.sv ----
// Purpose: front panel logic: address latch, decoder, led register, switch gate, nv memory
// Assumes: processor keeps its bus protocol; supply_low from a comparator pin
// Notes: nv memory modelled as volatile and nonvolatile arrays
`timescale 1ns/10ps
// Operation
// [RULE1] latch low address byte each bus cycle
// [RULE2] decode address with processor control signals
// [RULE3] led strobe loads led register from bus
// [RULE4] nv select only inside nv range
// [RULE5] switches driven only during switch read
// [RULE6] direction low means processor writes panel
// [RULE7] return buffer enabled during panel reads
// [RULE8] display select only on status variant
// [RULE9] processor polls switches every 30 ms
// [RULE10] processor refreshes leds every 30 ms
// [RULE11] individual or matrix switch inputs by variant
// [RULE12] supply low sets latch driving save
// [RULE13] save copies whole volatile array
// [RULE14] processor asserts restore at power up
// [RULE15] processor uses only volatile array normally
// [RULE16] saved state keeps last start action
// [RULE17] supply low flags 4.67 V threshold
// [RULE18] reset clears power fail latch
module panel_end
  import panel_pkg::*;
#(
  parameter bit status_variant = 1'b1,
  parameter int sw_width = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  panel_bus_if.panel bus,
  input wire logic [sw_width-1:0] switch_raw,
  input wire logic [3:0] matrix_col,
  output logic [7:0] led_out,
  output logic [7:0] display_data,
  output logic display_select,
  output logic nv_memory_select,
  output logic led_output_strobe,
  output logic return_buffer_enable,
  output logic save_active
);
  // ==========================================================
  // pin synchronisers
  logic supply_low_s1, supply_low_s2;
  logic [sw_width-1:0] sw_s1, sw_s2;
  logic [3:0] col_s1, col_s2;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_low_s1 <= 1'b0;
      supply_low_s2 <= 1'b0;
      sw_s1 <= '0;
      sw_s2 <= '0;
      col_s1 <= 4'h0;
      col_s2 <= 4'h0;
    end else begin
      supply_low_s1 <= bus.supply_low; // [RULE17]
      supply_low_s2 <= supply_low_s1;
      sw_s1 <= switch_raw;
      sw_s2 <= sw_s1;
      col_s1 <= matrix_col;
      col_s2 <= col_s1;
    end
  end
  // ==========================================================
  // address holding register
  logic [7:0] addr_hold;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) addr_hold <= 8'h00;
    else if (bus.addr_strobe) addr_hold <= bus.ad; // [RULE1]
  end
  // ==========================================================
  // decoder
  logic led_hit, sw_hit, disp_hit, nv_sel;
  always_comb begin
    led_hit = bus.data_strobe && !bus.rd_wr && addr_hold == led_addr; // [RULE2]
    sw_hit = bus.data_strobe && bus.rd_wr && addr_hold == switch_addr; // [RULE5]
    disp_hit = status_variant && bus.data_strobe && addr_hold == display_addr; // [RULE8]
    nv_sel = bus.data_strobe && nv_hit(addr_hold); // [RULE4]
  end
  assign led_output_strobe = led_hit; // [RULE3]
  assign display_select = disp_hit;
  assign nv_memory_select = nv_sel;
  // only reads of a panel peripheral turn the return buffer on
  assign return_buffer_enable = bus.data_strobe && bus.rd_wr &&
    (sw_hit || nv_sel || disp_hit); // [RULE6] [RULE7]
  // ==========================================================
  // switch sources by variant
  logic [7:0] sw_word;
  always_comb begin
    if (status_variant) begin
      // matrix decoder: column select and row input folded into one code
      sw_word = {col_s2, sw_s2[3:0]}; // [RULE11]
    end else begin
      sw_word = 8'(sw_s2); // [RULE11]
    end
  end
  // ==========================================================
  // led register and display latch
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) led_out <= led_reset;
    else if (led_hit) led_out <= bus.ad; // [RULE3]
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) display_data <= 8'h00;
    else if (disp_hit && !bus.rd_wr) display_data <= bus.ad;
  end
  // ==========================================================
  // power fail latch and nv memory
  logic pf_latch, pf_latch_d;
  logic [7:0] vol_mem [nv_words];
  // a blank part reads as zero until its first save
  logic [7:0] nv_mem [nv_words] = '{default: 8'h00};
  logic [6:0] nv_idx;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) pf_latch <= 1'b0; // [RULE18]
    else if (supply_low_s2) pf_latch <= 1'b1; // [RULE12]
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) pf_latch_d <= 1'b0;
    else pf_latch_d <= pf_latch;
  end
  assign save_active = pf_latch;
  assign nv_idx = addr_hold[6:0];
  // whole-array copy in one edge keeps the save atomic against further supply droop
  always_ff @(posedge mclk) begin
    if (pf_latch && !pf_latch_d) begin
      for (int i = 0; i < nv_words; i++) nv_mem[i] <= vol_mem[i]; // [RULE13] [RULE16]
    end
  end
  always_ff @(posedge mclk) begin
    if (bus.restore_cmd) begin
      for (int i = 0; i < nv_words; i++) vol_mem[i] <= nv_mem[i]; // [RULE14]
    end else if (nv_sel && !bus.rd_wr && !pf_latch) begin
      vol_mem[nv_idx] <= bus.ad; // [RULE15]
    end
  end
  // ==========================================================
  // read data
  logic [7:0] rd_data;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) rd_data <= 8'h00;
    else if (sw_hit) rd_data <= sw_word; // [RULE5]
    else if (nv_sel) rd_data <= vol_mem[nv_idx];
    else if (disp_hit) rd_data <= display_data;
  end
  assign bus.ad_panel = rd_data;
  logic rd_drive;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) rd_drive <= 1'b0;
    else rd_drive <= return_buffer_enable;
  end
  assign bus.ad_panel_oe_n = !(rd_drive && bus.data_strobe && bus.rd_wr); // [RULE7]
endmodule // panel_end

// ---- host_end.sv ----
// Purpose: processor side: restore at power up, 30 ms switch poll and led refresh
// Assumes: panel answers reads one cycle after the data strobe begins
// Notes: start switch toggles saved start bit held in nv word 0
`timescale 1ns/10ps
module host_end
  import panel_pkg::*;
#(
  parameter int poll_count = poll_cycles
) (
  input wire logic mclk,
  input wire logic sys_rst,
  panel_bus_if.host bus,
  input wire logic [7:0] led_value,
  output logic [7:0] switch_state,
  output logic start_state,
  output logic poll_done
);
  host_state_t state, next_state;
  logic [31:0] tick;
  logic [2:0] phase;
  logic [7:0] prev_sw;
  // ==========================================================
  // poll timer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) tick <= 32'h0;
    else if (state == st_idle && tick >= 32'(poll_count - 1)) tick <= 32'h0;
    else if (state == st_idle) tick <= tick + 32'h1; // [RULE9] [RULE10]
  end
  // ==========================================================
  // sequencer: each access is addr, strobe, strobe (3 cycles)
  always_comb begin
    next_state = state;
    case (state)
      st_recall: if (phase == 3'(recall_cycles - 1)) next_state = st_read_nv; // [RULE14]
      // the saved start action is read back before the first poll
      st_read_nv: if (phase == 3'h2) next_state = st_idle; // [RULE16]
      st_idle: if (tick >= 32'(poll_count - 1)) next_state = st_read_sw;
      st_read_sw: if (phase == 3'h2) next_state = st_write_led;
      st_write_led: if (phase == 3'h2) next_state = st_write_nv;
      st_write_nv: if (phase == 3'h2) next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) state <= st_recall;
    else state <= next_state;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) phase <= 3'h0;
    else if (next_state != state) phase <= 3'h0;
    else phase <= phase + 3'h1;
  end
  // ==========================================================
  // bus drive
  always_comb begin
    bus.restore_cmd = state == st_recall;
    bus.addr_strobe = 1'b0;
    bus.data_strobe = 1'b0;
    bus.rd_wr = 1'b1;
    bus.ad_host = 8'h00;
    bus.ad_host_oe_n = 1'b1;
    case (state)
      st_read_sw, st_write_led, st_write_nv, st_read_nv: begin
        bus.rd_wr = state == st_read_sw || state == st_read_nv;
        if (phase == 3'h0) begin
          bus.addr_strobe = 1'b1;
          bus.ad_host_oe_n = 1'b0;
          bus.ad_host = state == st_read_sw ? switch_addr :
            (state == st_write_led ? led_addr : nv_base); // [RULE15]
        end else begin
          bus.data_strobe = 1'b1;
          bus.ad_host_oe_n = state == st_read_sw || state == st_read_nv;
          bus.ad_host = state == st_write_led ? led_value : {7'h00, start_state};
        end
      end
      default: ;
    endcase
  end
  // ==========================================================
  // captured results
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      switch_state <= 8'h00;
      prev_sw <= 8'h00;
      start_state <= 1'b0;
      poll_done <= 1'b0;
    end else begin
      poll_done <= 1'b0;
      if (state == st_read_nv && phase == 3'h2) start_state <= bus.ad[start_bit]; // [RULE16]
      if (state == st_read_sw && phase == 3'h2) begin
        switch_state <= bus.ad;
        prev_sw <= bus.ad;
        poll_done <= 1'b1;
        if (bus.ad[start_bit] && !prev_sw[start_bit]) start_state <= !start_state; // [RULE16]
      end
    end
  end
endmodule // host_end

// ---- front_panel_bus_chk.sv ----
// Purpose: concurrent checks on the panel bus link
// Assumes: one clock mclk, asynchronous active-high reset
// Notes: sees only the interface signals
`timescale 1ns/10ps
module front_panel_bus_chk
  import panel_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic addr_strobe,
  input wire logic [7:0] ad,
  input wire logic ad_host_oe_n,
  input wire logic ad_panel_oe_n,
  input wire logic rd_wr,
  input wire logic data_strobe,
  input wire logic restore_cmd
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // helper: our own copy of the latched address byte
  logic [7:0] addr_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) addr_q <= 8'h00;
    else if (addr_strobe) addr_q <= ad;
  end
  // ==========================================================
  // assertions
  one_driver_a: assert property (!(!ad_host_oe_n && !ad_panel_oe_n))
    else $error("both ends drive the bus");
  panel_drive_a: assert property (!ad_panel_oe_n |-> rd_wr && data_strobe)
    else $error("panel drives outside a read");
  addr_phase_a: assert property (addr_strobe |-> !ad_host_oe_n && ad_panel_oe_n)
    else $error("address phase not driven by host");
  addr_then_data_a: assert property (addr_strobe |=> data_strobe)
    else $error("no data strobe after address");
  switch_read_a: assert property (
    $rose(data_strobe) && rd_wr && addr_q == switch_addr |=> !ad_panel_oe_n)
    else $error("switch read not answered");
  host_write_a: assert property (data_strobe && !rd_wr |-> !ad_host_oe_n)
    else $error("write without host driving");
  recall_quiet_a: assert property (restore_cmd |-> !addr_strobe && !data_strobe)
    else $error("bus access during restore");
  recall_len_a: assert property ($fell(restore_cmd) |-> $past(restore_cmd, 4))
    else $error("restore pulse too short");
  cover property (data_strobe && rd_wr);
  cover property (data_strobe && !rd_wr);
  cover property ($fell(restore_cmd));
endmodule // front_panel_bus_chk

// ---- front_panel_bus_interface_test.sv ----
// Purpose: both ends joined; polls, leds, start toggle, power fail
// Assumes: operator variant, short poll count
// Notes: expectations come from stimulus, except start_state, checked against its own earlier value
`timescale 1ns/10ps
module front_panel_bus_interface_test;
  import panel_pkg::*;
  logic mclk, sys_rst;
  logic [7:0] switch_raw, led_value, led_out, switch_state;
  logic disp_sel, nv_sel, led_stb, rbe, save_active, start_state, poll_done;
  logic seen_disp, seen_nv, seen_led, seen_rbe, saved;
  int n_fail, checks;
  panel_bus_if link();
  panel_end #(.status_variant(1'b0), .sw_width(8)) i_panel_end (.mclk(mclk),
    .sys_rst(sys_rst), .bus(link), .switch_raw(switch_raw), .matrix_col(4'h0),
    .led_out(led_out), .display_data(), .display_select(disp_sel),
    .nv_memory_select(nv_sel), .led_output_strobe(led_stb),
    .return_buffer_enable(rbe), .save_active(save_active));
  host_end #(.poll_count(20)) i_host_end (.mclk(mclk), .sys_rst(sys_rst), .bus(link),
    .led_value(led_value), .switch_state(switch_state), .start_state(start_state),
    .poll_done(poll_done));
  front_panel_bus_chk i_chk (.mclk(mclk), .sys_rst(sys_rst),
    .addr_strobe(link.addr_strobe), .ad(link.ad), .ad_host_oe_n(link.ad_host_oe_n),
    .ad_panel_oe_n(link.ad_panel_oe_n), .rd_wr(link.rd_wr),
    .data_strobe(link.data_strobe), .restore_cmd(link.restore_cmd));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (disp_sel === 1'b1) seen_disp <= 1'b1;
    if (nv_sel === 1'b1) seen_nv <= 1'b1;
    if (led_stb === 1'b1) seen_led <= 1'b1;
    if (rbe === 1'b1) seen_rbe <= 1'b1;
  end
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_polls(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 400) begin
      @(posedge mclk);
      #1;
      k++;
      if (poll_done === 1'b1) n--;
    end
    if (n > 0) begin
      n_fail++;
      $display("MISMATCH %0t poll never completed", $time);
      tally_and_finish();
    end
  endtask
  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    cmp(led_out, led_reset);
    cmp({7'h0, save_active}, 8'h00);
    @(posedge mclk);
    sys_rst <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic poll_and_leds();
    @(posedge mclk);
    led_value <= 8'h5a;
    switch_raw <= 8'h3c;
    wait_polls(2);
    cmp(led_out, 8'h5a);
    cmp(switch_state, 8'h3c);
    @(posedge mclk);
    led_value <= 8'ha5;
    switch_raw <= 8'hc2;
    wait_polls(2);
    cmp(led_out, 8'ha5);
    cmp(switch_state, 8'hc2);
  endtask
  task automatic start_toggle();
    logic s0;
    @(posedge mclk);
    switch_raw <= 8'h3c;
    wait_polls(2);
    s0 = start_state;
    @(posedge mclk);
    switch_raw <= 8'h3d;
    wait_polls(2);
    cmp({7'h0, start_state}, {7'h0, ~s0});
    @(posedge mclk);
    switch_raw <= 8'h3c;
    wait_polls(2);
    cmp({7'h0, start_state}, {7'h0, ~s0});
    saved = ~s0;
  endtask
  task automatic power_fail();
    @(posedge mclk);
    link.supply_low <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    cmp({7'h0, save_active}, 8'h01);
    link.supply_low <= 1'b0;
    wait_polls(2);
    cmp({7'h0, save_active}, 8'h01);
    do_reset();
    wait_polls(2);
    cmp({7'h0, start_state}, {7'h0, saved});
  endtask
  initial begin
    sys_rst = 1'b1;
    switch_raw = 8'h00;
    led_value = 8'h00;
    link.supply_low = 1'b0;
    {seen_disp, seen_nv, seen_led, seen_rbe, saved} = 5'h00;
    n_fail = 0;
    checks = 0;
    do_reset();
    poll_and_leds();
    start_toggle();
    power_fail();
    cmp({4'h0, seen_disp, seen_nv, seen_led, seen_rbe}, 8'h07);
    tally_and_finish();
  end
endmodule // front_panel_bus_interface_test
